// ### bfp_pkg.sv
// constants, carrier types and the shared control decoder for the
// bidirectional fifo port block.
// assumes one system clock; port clocks and resets arrive as sampled levels.

package bfp_pkg;

  localparam int         DATA_W         = 36;
  localparam int         FIFO_DEPTH     = 16;
  localparam int         OFFSET_W       = 10;
  localparam int         PRESET_BOTH    = 64;
  localparam int         PRESET_FS1     = 16;
  localparam int         PRESET_FS0     = 8;
  localparam logic [1:0] IN_READY_EDGES = 2'h2;
  localparam logic [1:0] PROG_FULL1     = 2'h0;
  localparam logic [1:0] PROG_EMPTY1    = 2'h1;
  localparam logic [1:0] PROG_FULL2     = 2'h2;
  localparam logic [1:0] PROG_EMPTY2    = 2'h3;

  // one port's controls, write normalised to active high
  typedef struct packed {
    logic tick;
    logic sel_n;
    logic write;
    logic en;
    logic mb;
  } bfp_ctrl_t;

  typedef struct packed {
    logic fifo_wr;
    logic fifo_rd;
    logic mb_wr;
    logic mb_rd;
  } bfp_op_t;

  typedef struct packed {
    logic       mode_pend;
    logic       std_mode;
    logic [1:0] rdy_cnt;
    logic       in_ready;
    logic       sync1;
    logic       sync2;
    logic       out_ready;
  } bfp_dir_t;

  function automatic bfp_op_t bfp_decode(input bfp_ctrl_t c);
    bfp_op_t o;
    logic    go;
    go        = c.tick & ~c.sel_n & c.en;
    o.fifo_wr = go & c.write & ~c.mb;
    o.fifo_rd = go & ~c.write & ~c.mb;
    o.mb_wr   = go & c.write & c.mb;
    o.mb_rd   = go & ~c.write & c.mb;
    return o;
  endfunction : bfp_decode

endpackage : bfp_pkg

// ### bfp_port_ctrl.sv
// the two-direction fifo port block: offsets, decode, flags, mailboxes
// and the ring buffers themselves.
// assumes port clocks and fifo resets are synchronous to clk.
`default_nettype none

// ---------------------------------------------------------------------
// ring buffer
// ---------------------------------------------------------------------
module bfp_fifo #(
  parameter int WIDTH = bfp_pkg::DATA_W,
  parameter int DEPTH = bfp_pkg::FIFO_DEPTH,
  parameter int CW    = $clog2(DEPTH) + 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             clear,
  input  wire logic             s_valid,
  output logic                  s_ready,
  input  wire logic [WIDTH-1:0] s_data,
  output logic                  m_valid,
  input  wire logic             m_ready,
  output logic      [WIDTH-1:0] m_data,
  output logic      [CW-1:0]    count
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  logic [PW-1:0]    next_wptr;
  logic [PW-1:0]    next_rptr;
  logic [CW-1:0]    next_count;
  logic             do_push;
  logic             do_pop;

  assign s_ready = (count != CW'(DEPTH));
  assign m_valid = (count != '0);
  assign m_data  = mem[rptr];

  always_comb begin
    do_push    = s_valid & s_ready;
    do_pop     = m_valid & m_ready;
    next_wptr  = do_push ? PW'(wptr + 1'b1) : wptr;
    next_rptr  = do_pop ? PW'(rptr + 1'b1) : rptr;
    next_count = count;
    if (do_push && !do_pop) begin
      next_count = CW'(count + 1'b1);
    end else if (do_pop && !do_push) begin
      next_count = CW'(count - 1'b1);
    end
    if (clear) begin
      next_wptr  = '0;
      next_rptr  = '0;
      next_count = '0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else begin
      wptr  <= next_wptr;
      rptr  <= next_rptr;
      count <= next_count;
    end
    if (do_push && !clear) begin
      mem[wptr] <= s_data;
    end
  end
endmodule : bfp_fifo

// ---------------------------------------------------------------------
// port control top
// ---------------------------------------------------------------------
module bfp_port_ctrl #(
  parameter int DEPTH    = bfp_pkg::FIFO_DEPTH,
  parameter int OFFSET_W = bfp_pkg::OFFSET_W
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       fifo1_reset_n,
  input  wire logic                       fifo2_reset_n,
  input  wire logic                       flag_select0,
  input  wire logic                       flag_select1,
  input  wire logic                       fall_through_select,
  input  wire logic                       porta_clock,
  input  wire logic                       porta_select_n,
  input  wire logic                       porta_write_not_read,
  input  wire logic                       porta_enable,
  input  wire logic                       porta_mailbox_select,
  input  wire logic [bfp_pkg::DATA_W-1:0] porta_data_in,
  output logic      [bfp_pkg::DATA_W-1:0] porta_data_out,
  output logic                            porta_data_oe_n,
  output logic                            porta_full_or_in_ready,
  output logic                            porta_empty_or_out_ready,
  output logic                            porta_almost_empty_n,
  output logic                            porta_almost_full_n,
  output logic                            mail1_flag_n,
  input  wire logic                       portb_clock,
  input  wire logic                       portb_select_n,
  input  wire logic                       portb_read_not_write,
  input  wire logic                       portb_enable,
  input  wire logic                       portb_mailbox_select,
  input  wire logic [bfp_pkg::DATA_W-1:0] portb_data_in,
  output logic      [bfp_pkg::DATA_W-1:0] portb_data_out,
  output logic                            portb_data_oe_n,
  output logic                            portb_full_or_in_ready,
  output logic                            portb_empty_or_out_ready,
  output logic                            portb_almost_empty_n,
  output logic                            portb_almost_full_n,
  output logic                            mail2_flag_n
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int XW = OFFSET_W + CW;
  localparam int DW = bfp_pkg::DATA_W;

  // index 0 is port A / fifo1 / mail1, index 1 is port B / fifo2 / mail2
  bfp_pkg::bfp_ctrl_t ctl [2];
  bfp_pkg::bfp_op_t   op  [2];
  logic [DW-1:0]      pdin [2];
  logic [DW-1:0]      out_q [2];
  logic [DW-1:0]      mail [2];
  logic [1:0]         rstn;
  logic [1:0]         rst_rise;
  logic [1:0]         pclk_rise;
  logic [1:0]         in_flag;
  logic [1:0]         out_flag;
  logic [1:0]         ae_n;
  logic [1:0]         af_n;
  logic [1:0]         push;
  logic [1:0]         pop;
  logic [1:0]         mflag_n;
  logic [1:0]         fs;

  function automatic logic [OFFSET_W-1:0] preset(input logic [1:0] sel);
    logic [OFFSET_W-1:0] v;
    v = OFFSET_W'(bfp_pkg::PRESET_FS0);
    if (sel == 2'h3) begin
      v = OFFSET_W'(bfp_pkg::PRESET_BOTH);
    end else if (sel == 2'h2) begin
      v = OFFSET_W'(bfp_pkg::PRESET_FS1);
    end
    return v;
  endfunction : preset

  // ---------------------------------------------------------------------
  // edges of port clocks and fifo resets
  // ---------------------------------------------------------------------
  logic [1:0] pclk_q;
  logic [1:0] rstn_q;
  logic [1:0] next_pclk_q;
  logic [1:0] next_rstn_q;

  assign rstn = {fifo2_reset_n, fifo1_reset_n};
  assign fs   = {flag_select1, flag_select0};

  always_comb begin
    next_pclk_q = {portb_clock, porta_clock};
    next_rstn_q = rstn;
    pclk_rise   = next_pclk_q & ~pclk_q;
    rst_rise    = rstn & ~rstn_q;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pclk_q <= 2'h3;
      rstn_q <= 2'h3;
    end else begin
      pclk_q <= next_pclk_q;
      rstn_q <= next_rstn_q;
    end
  end

  // ---------------------------------------------------------------------
  // port decode and bus drive
  // ---------------------------------------------------------------------
  always_comb begin
    ctl[0] = '{tick: pclk_rise[0], sel_n: porta_select_n,
               write: porta_write_not_read, en: porta_enable,
               mb: porta_mailbox_select};
    ctl[1] = '{tick: pclk_rise[1], sel_n: portb_select_n,
               write: ~portb_read_not_write, en: portb_enable,
               mb: portb_mailbox_select};
    op[0]  = bfp_pkg::bfp_decode(ctl[0]);
    op[1]  = bfp_pkg::bfp_decode(ctl[1]);
  end

  assign pdin[0]         = porta_data_in;
  assign pdin[1]         = portb_data_in;
  assign porta_data_oe_n = porta_select_n | porta_write_not_read;
  assign portb_data_oe_n = portb_select_n | ~portb_read_not_write;
  // mailbox select steers the bus at once, both sources are registers
  assign porta_data_out  = porta_mailbox_select ? mail[1] : out_q[1];
  assign portb_data_out  = portb_mailbox_select ? mail[0] : out_q[0];

  // ---------------------------------------------------------------------
  // offset registers and port A programming
  // ---------------------------------------------------------------------
  logic [OFFSET_W-1:0] empty_off [2];
  logic [OFFSET_W-1:0] full_off  [2];
  logic [OFFSET_W-1:0] next_empty_off [2];
  logic [OFFSET_W-1:0] next_full_off  [2];
  logic                prog_busy;
  logic [1:0]          prog_cnt;
  logic                next_prog_busy;
  logic [1:0]          next_prog_cnt;
  logic                prog_take;
  logic [OFFSET_W-1:0] prog_val;

  always_comb begin
    next_empty_off = empty_off;
    next_full_off  = full_off;
    next_prog_busy = prog_busy;
    next_prog_cnt  = prog_cnt;
    prog_val       = porta_data_in[OFFSET_W-1:0];
    prog_take      = prog_busy & op[0].fifo_wr & in_flag[0];
    for (int k = 0; k < 2; k++) begin
      // selects are read the same way in either timing mode
      if (rst_rise[k] && fs != 2'h0) begin
        next_empty_off[k] = preset(fs);
        next_full_off[k]  = preset(fs);
        next_prog_busy    = 1'b0;
      end
    end
    if (&rst_rise && fs == 2'h0) begin
      next_prog_busy = 1'b1;
      next_prog_cnt  = bfp_pkg::PROG_FULL1;
    end else if (prog_take) begin
      case (prog_cnt)
        bfp_pkg::PROG_FULL1:  next_full_off[0]  = prog_val;
        bfp_pkg::PROG_EMPTY1: next_empty_off[0] = prog_val;
        bfp_pkg::PROG_FULL2:  next_full_off[1]  = prog_val;
        default:              next_empty_off[1] = prog_val;
      endcase
      next_prog_cnt = 2'(prog_cnt + 1'b1);
      if (prog_cnt == bfp_pkg::PROG_EMPTY2) begin
        next_prog_busy = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      empty_off <= '{default: '0};
      full_off  <= '{default: '0};
      prog_busy <= 1'b0;
      prog_cnt  <= 2'h0;
    end else begin
      empty_off <= next_empty_off;
      full_off  <= next_full_off;
      prog_busy <= next_prog_busy;
      prog_cnt  <= next_prog_cnt;
    end
  end

  // ---------------------------------------------------------------------
  // one direction per fifo: writer port i, reader port 1-i
  // ---------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_dir
    localparam int R = 1 - i;

    bfp_pkg::bfp_dir_t s;
    bfp_pkg::bfp_dir_t next_s;
    logic [DW-1:0]     next_out;
    logic              f_valid;
    logic              f_ready;
    logic [DW-1:0]     head;
    logic [CW-1:0]     cnt;
    logic              avail;
    logic              fw_fill;
    logic              fw_rd;
    logic              blocked;

    bfp_fifo #(
      .WIDTH (DW),
      .DEPTH (DEPTH),
      .CW    (CW)
    ) u_fifo (
      .clk     (clk),
      .rst     (rst),
      .clear   (~rstn[i]),
      .s_valid (push[i]),
      .s_ready (f_ready),
      .s_data  (pdin[i]),
      .m_valid (f_valid),
      .m_ready (pop[i]),
      .m_data  (head),
      .count   (cnt)
    );

    always_comb begin
      // fifo1 memory and port B input wait for the offset load to finish
      blocked     = prog_busy;
      avail       = s.sync2 & f_valid;
      in_flag[i]  = s.in_ready & f_ready & ~(i == 1 && blocked);
      out_flag[R] = s.std_mode ? avail : s.out_ready;
      push[i]     = op[i].fifo_wr & in_flag[i]
                    & ~(i == 0 && blocked);
      fw_fill     = pclk_rise[R] & ~s.out_ready & avail;
      fw_rd       = op[R].fifo_rd & s.out_ready;
      if (s.std_mode) begin
        pop[i] = op[R].fifo_rd & avail;
      end else begin
        pop[i] = fw_fill | (fw_rd & avail);
      end
      ae_n[R] = rstn[i] & (XW'(cnt) > XW'(empty_off[i]));
      af_n[i] = ~rstn[i] | (XW'(cnt) + XW'(full_off[i]) < XW'(DEPTH));
      next_s   = s;
      next_out = out_q[i];
      if (!rstn[i]) begin
        next_s           = '0;
        next_s.mode_pend = 1'b1;
      end else begin
        if (pclk_rise[i]) begin
          if (s.mode_pend) begin
            next_s.std_mode  = fall_through_select;
            next_s.mode_pend = 1'b0;
          end
          if (s.rdy_cnt != bfp_pkg::IN_READY_EDGES) begin
            next_s.rdy_cnt  = 2'(s.rdy_cnt + 1'b1);
            next_s.in_ready = (2'(s.rdy_cnt + 1'b1) ==
                               bfp_pkg::IN_READY_EDGES);
          end
        end
        if (pclk_rise[R]) begin
          // second read edge after a write sees the word
          next_s.sync1 = f_valid;
          next_s.sync2 = s.sync1;
        end
        if (pop[i] && cnt == CW'(1)) begin
          next_s.sync1 = 1'b0;
          next_s.sync2 = 1'b0;
        end
        if (pop[i]) begin
          next_out = head;
        end
        if (!s.std_mode && fw_fill) begin
          next_s.out_ready = 1'b1;
        end else if (!s.std_mode && fw_rd && !avail) begin
          next_s.out_ready = 1'b0;
        end
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        s        <= '0;
        out_q[i] <= '0;
      end else begin
        s        <= next_s;
        out_q[i] <= next_out;
      end
    end
  end

  assign porta_full_or_in_ready   = in_flag[0];
  assign portb_full_or_in_ready   = in_flag[1];
  assign porta_empty_or_out_ready = out_flag[0];
  assign portb_empty_or_out_ready = out_flag[1];
  assign porta_almost_empty_n     = ae_n[0];
  assign portb_almost_empty_n     = ae_n[1];
  assign porta_almost_full_n      = af_n[0];
  assign portb_almost_full_n      = af_n[1];

  // ---------------------------------------------------------------------
  // mailboxes: mail j written by port j, read by port 1-j
  // ---------------------------------------------------------------------
  for (genvar j = 0; j < 2; j++) begin : g_mail
    logic [DW-1:0] next_mail;
    logic          next_flag_n;

    always_comb begin
      next_mail   = mail[j];
      next_flag_n = mflag_n[j];
      if (op[j].mb_wr) begin
        next_mail = pdin[j];
      end
      // new mail wins over a read in the same cycle
      if (!rstn[j]) begin
        next_flag_n = 1'b1;
      end else if (op[j].mb_wr) begin
        next_flag_n = 1'b0;
      end else if (op[1-j].mb_rd) begin
        next_flag_n = 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        mail[j]    <= '0;
        mflag_n[j] <= 1'b1;
      end else begin
        mail[j]    <= next_mail;
        mflag_n[j] <= next_flag_n;
      end
    end
  end

  assign mail1_flag_n = mflag_n[0];
  assign mail2_flag_n = mflag_n[1];

  // ---------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------
  AST_PORTA_DRIVE: assert property (@(posedge clk) disable iff (rst)
    !porta_data_oe_n |-> !porta_select_n && !porta_write_not_read)
    else $error("port A bus driven outside a read select");

  AST_PORTB_DRIVE: assert property (@(posedge clk) disable iff (rst)
    !portb_data_oe_n |-> !portb_select_n && portb_read_not_write)
    else $error("port B bus driven outside a read select");

  AST_PRESET_64: assert property (@(posedge clk) disable iff (rst)
    rst_rise[0] && fs == 2'h3 |=>
      full_off[0] == OFFSET_W'(64) && empty_off[0] == OFFSET_W'(64))
    else $error("fifo1 preset 64 not loaded");

  AST_PRESET_8: assert property (@(posedge clk) disable iff (rst)
    rst_rise[1] && fs == 2'h1 |=>
      full_off[1] == OFFSET_W'(8) && empty_off[1] == OFFSET_W'(8))
    else $error("fifo2 preset 8 not loaded");

  AST_PROG_FIRST: assert property (@(posedge clk) disable iff (rst)
    prog_take && prog_cnt == 2'h0 |=>
      full_off[0] == $past(porta_data_in[OFFSET_W-1:0]) && !push[0])
    else $error("first offset write not steered to fifo1 full offset");

  AST_PROG_BLOCK: assert property (@(posedge clk) disable iff (rst)
    prog_busy |-> !portb_full_or_in_ready && !push[0])
    else $error("port B ready or fifo1 write during offset load");

  AST_PROG_DONE: assert property (@(posedge clk) disable iff (rst)
    prog_take && prog_cnt == 2'h3 && !(&rst_rise) |=> !prog_busy)
    else $error("offset load did not end after fourth write");

  AST_IDLE_PORT: assert property (@(posedge clk) disable iff (rst)
    !porta_enable |-> !push[0] && $stable(mail[0]) &&
      (!pop[1] || (g_dir[1].fw_fill && !g_dir[1].s.std_mode)))
    else $error("port A acted with enable low");

  AST_MAIL_SET: assert property (@(posedge clk) disable iff (rst)
    op[0].mb_wr && fifo1_reset_n |=>
      !mail1_flag_n && mail[0] == $past(pdin[0]))
    else $error("mail1 write did not raise new mail");

  AST_MAIL_READ: assert property (@(posedge clk) disable iff (rst)
    op[1].mb_rd && !op[0].mb_wr |=> mail1_flag_n)
    else $error("mail1 read did not clear the flag");

endmodule : bfp_port_ctrl

`default_nettype wire

// ### bfp_port_model.sv
// processor model for one port: port clock pin, controls and data in.
// assumes calls arrive on the falling edge of clk; the pin idles low.
`default_nettype none
// ---------------------------------------------------------------------
// port master
// ---------------------------------------------------------------------
module bfp_port_model #(
  parameter logic WR = 1'h1
) (
  input  wire logic                       clk,
  output logic                            pclk,
  output logic                            sel_n,
  output logic                            wsense,
  output logic                            en,
  output logic                            mb,
  output logic      [bfp_pkg::DATA_W-1:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    pclk   = 1'h0;
    sel_n  = 1'h1;
    wsense = ~WR;
    en     = 1'h0;
    mb     = 1'h0;
    data   = '0;
  end
  // a bus that is not written shows the inverse, never a stale copy
  task automatic set(input logic s, w, e, m,
                     input logic [bfp_pkg::DATA_W-1:0] d);
    sel_n  = s;
    wsense = w;
    en     = e;
    mb     = m;
    data   = (!s && w == WR) ? d : ~data;
  endtask : set
  // one pulse is one port edge; controls hold across it
  task automatic tick();
    @(negedge clk);
    pclk = 1'h1;
    @(negedge clk);
    pclk = 1'h0;
    @(negedge clk);
  endtask : tick
endmodule : bfp_port_model
`default_nettype wire

// ### bfp_port_ctrl_tb.sv
// self-checking bench for the fifo port block, one model on each port.
// assumes the package, the design and the port model are compiled first.
`default_nettype none
`define BFP_CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin \
  n_mismatch++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
// ---------------------------------------------------------------------
// bench top
// ---------------------------------------------------------------------
module bfp_port_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [bfp_pkg::DATA_W-1:0] bfp_word_t;
  logic      clk, rst, fifo1_reset_n, fifo2_reset_n;
  logic      flag_select0, flag_select1, fall_through_select;
  logic      porta_clock, porta_select_n, porta_write_not_read, porta_enable;
  logic      porta_mailbox_select, porta_data_oe_n, porta_full_or_in_ready;
  logic      porta_empty_or_out_ready, porta_almost_empty_n;
  logic      porta_almost_full_n, mail1_flag_n, mail2_flag_n;
  logic      portb_clock, portb_select_n, portb_read_not_write, portb_enable;
  logic      portb_mailbox_select, portb_data_oe_n, portb_full_or_in_ready;
  logic      portb_empty_or_out_ready, portb_almost_empty_n;
  logic      portb_almost_full_n;
  bfp_word_t porta_data_in, porta_data_out, portb_data_in, portb_data_out;
  int        n_mismatch, samples_checked;

  bfp_port_ctrl i_dut (.clk, .rst, .fifo1_reset_n, .fifo2_reset_n,
    .flag_select0, .flag_select1, .fall_through_select, .porta_clock,
    .porta_select_n, .porta_write_not_read, .porta_enable,
    .porta_mailbox_select, .porta_data_in, .porta_data_out, .porta_data_oe_n,
    .porta_full_or_in_ready, .porta_empty_or_out_ready, .porta_almost_empty_n,
    .porta_almost_full_n, .mail1_flag_n, .portb_clock, .portb_select_n,
    .portb_read_not_write, .portb_enable, .portb_mailbox_select,
    .portb_data_in, .portb_data_out, .portb_data_oe_n, .portb_full_or_in_ready,
    .portb_empty_or_out_ready, .portb_almost_empty_n, .portb_almost_full_n,
    .mail2_flag_n);
  bfp_port_model #(.WR(1'h1)) i_pa (.clk, .pclk(porta_clock),
    .sel_n(porta_select_n), .wsense(porta_write_not_read),
    .en(porta_enable), .mb(porta_mailbox_select), .data(porta_data_in));
  bfp_port_model #(.WR(1'h0)) i_pb (.clk, .pclk(portb_clock),
    .sel_n(portb_select_n), .wsense(portb_read_not_write),
    .en(portb_enable), .mb(portb_mailbox_select), .data(portb_data_in));

  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  function automatic bfp_word_t wv(input int i);
    return 36'ha00000000 | bfp_word_t'(i * 3 + 1);
  endfunction : wv
  task automatic a_op(input logic w, e, m, input bfp_word_t d);
    i_pa.set(1'h0, w, e, m, d);
    i_pa.tick();
  endtask : a_op
  task automatic b_op(input logic w, e, m, input bfp_word_t d);
    i_pb.set(1'h0, w, e, m, d);
    i_pb.tick();
  endtask : b_op
  // both resets rise together; fifo1 comes up standard, fifo2 fall-through
  task automatic mreset(input logic f1, f0);
    fifo1_reset_n = 1'h0;
    fifo2_reset_n = 1'h0;
    flag_select1  = f1;
    flag_select0  = f0;
    repeat (2) @(negedge clk);
    fifo1_reset_n = 1'h1;
    fifo2_reset_n = 1'h1;
    @(negedge clk);
    fall_through_select = 1'h1;
    repeat (2) a_op(1'h1, 1'h0, 1'h0, '0);
    fall_through_select = 1'h0;
    repeat (2) b_op(1'h0, 1'h0, 1'h0, '0);
  endtask : mreset
  task automatic t_preset();
    logic [1:0] code [3] = '{2'h3, 2'h2, 2'h1};
    foreach (code[k]) begin
      mreset(code[k][1], code[k][0]);
      `BFP_CHK("a_af", code[k] == 2'h1, porta_almost_full_n)
      `BFP_CHK("b_af", code[k] == 2'h1, portb_almost_full_n)
    end
    for (int i = 1; i <= 17; i++) begin
      a_op(1'h1, 1'h1, 1'h0, wv(i));
      `BFP_CHK("a_af", i < 8, porta_almost_full_n)
      `BFP_CHK("b_ae", i > 8, portb_almost_empty_n)
      `BFP_CHK("a_ir", i < 16, porta_full_or_in_ready)
    end
    repeat (2) b_op(1'h1, 1'h0, 1'h0, '0);
    for (int i = 1; i <= 16; i++) begin
      `BFP_CHK("b_ef", 1'h1, portb_empty_or_out_ready)
      b_op(1'h1, 1'h1, 1'h0, '0);
      `BFP_CHK("b_dat", wv(i), portb_data_out)
    end
    `BFP_CHK("b_ef", 1'h0, portb_empty_or_out_ready)
    `BFP_CHK("b_oe", 1'h0, portb_data_oe_n)
    $display("t_preset done");
  endtask : t_preset
  task automatic t_prog();
    // offsets in range, upper bits set so only the low field may count
    bfp_word_t offs [4] = '{36'hffffffc03, 36'hffffffc02, 36'hffffffc05,
                            36'hffffffc04};
    mreset(1'h0, 1'h0);
    foreach (offs[k]) begin
      a_op(1'h1, 1'h1, 1'h0, offs[k]);
      `BFP_CHK("b_ir", k == 3, portb_full_or_in_ready)
    end
    for (int i = 1; i <= 3; i++) begin
      a_op(1'h1, 1'h1, 1'h0, wv(i));
      `BFP_CHK("b_ae", i > 2, portb_almost_empty_n)
    end
    b_op(1'h1, 1'h0, 1'h0, '0);
    `BFP_CHK("b_ef", 1'h0, portb_empty_or_out_ready)
    b_op(1'h1, 1'h0, 1'h0, '0);
    `BFP_CHK("b_ef", 1'h1, portb_empty_or_out_ready)
    `BFP_CHK("b_dat", 1'h0, portb_data_out === wv(1))
    b_op(1'h1, 1'h1, 1'h0, '0);
    `BFP_CHK("b_dat", wv(1), portb_data_out)
    for (int i = 1; i <= 5; i++) begin
      b_op(1'h0, 1'h1, 1'h0, wv(i + 20));
      `BFP_CHK("a_ae", i > 4, porta_almost_empty_n)
    end
    for (int i = 1; i <= 3; i++) begin
      a_op(1'h1, 1'h0, 1'h0, '0);
      `BFP_CHK("a_or", i == 3, porta_empty_or_out_ready)
    end
    `BFP_CHK("a_dat", wv(21), porta_data_out)
    fork
      a_op(1'h0, 1'h1, 1'h0, '0);
      b_op(1'h0, 1'h1, 1'h0, wv(26));
    join
    `BFP_CHK("a_dat", wv(22), porta_data_out)
    `BFP_CHK("a_oe", 1'h0, porta_data_oe_n)
    $display("t_prog done");
  endtask : t_prog
  task automatic t_mail();
    a_op(1'h1, 1'h1, 1'h1, 36'h123456789);
    `BFP_CHK("m1", 1'h0, mail1_flag_n)
    b_op(1'h0, 1'h0, 1'h1, 36'h0aaaa5555);
    `BFP_CHK("m2", 1'h1, mail2_flag_n)
    b_op(1'h1, 1'h1, 1'h1, '0);
    `BFP_CHK("m1", 1'h1, mail1_flag_n)
    `BFP_CHK("b_dat", 36'h123456789, portb_data_out)
    b_op(1'h0, 1'h1, 1'h1, 36'h0aaaa5555);
    `BFP_CHK("m2", 1'h0, mail2_flag_n)
    a_op(1'h0, 1'h1, 1'h1, '0);
    `BFP_CHK("m2", 1'h1, mail2_flag_n)
    `BFP_CHK("a_dat", 36'h0aaaa5555, porta_data_out)
    $display("t_mail done");
  endtask : t_mail
  task automatic t_oe();
    for (int k = 0; k < 4; k++) begin
      @(negedge clk);
      i_pa.set(k[1], k[0], 1'h0, 1'h0, '0);
      i_pb.set(k[1], k[0], 1'h0, 1'h0, '0);
      #1;
      `BFP_CHK("a_oe", k[1] | k[0], porta_data_oe_n)
      `BFP_CHK("b_oe", k[1] | ~k[0], portb_data_oe_n)
    end
    $display("t_oe done");
  endtask : t_oe
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : conclude
  initial begin
    rst                 = 1'h1;
    fifo1_reset_n       = 1'h0;
    fifo2_reset_n       = 1'h0;
    flag_select0        = 1'h0;
    flag_select1        = 1'h0;
    fall_through_select = 1'h1;
    n_mismatch          = 0;
    samples_checked     = 0;
    repeat (5) @(negedge clk);
    rst = 1'h0;
    t_preset();
    t_prog();
    t_mail();
    t_oe();
    conclude();
  end
  // a hang counts as a mismatch and still reaches the verdict
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("run cut short by the watchdog");
    conclude();
  end
endmodule : bfp_port_ctrl_tb
`default_nettype wire
